// ==== core/ucr_top.sv ====
// Purpose: Control register of a full-speed USB device peripheral
// Assumes: Register port is a simple synchronous strobe port, 16-bit data
// Notes: Status register lives outside; only its flag links enter here
`timescale 1ns/100ps
`default_nettype none

// Function
// - Bit 15 enable gates the good-transfer flag onto the interrupt.
// - Bit 14 enable gates the packet memory overrun flag.
// - Bit 13 enable gates the bus error flag.
// - Bit 12 enable gates the wake flag.
// - Bit 11 enable gates the suspend flag.
// - Bit 10 enable gates the bus reset flag.
// - Bit 9 enable gates the frame start flag.
// - Bit 8 enable gates the expected frame event.
// - Resume bit 4 high drives resume signalling upstream.
// - Three ms without bus traffic sets the suspend flag.
// - Force suspend enters suspend mode; clocks and transceiver power stay.
// - Low power bit cuts static power; wake activity in suspend, not powered down, clears it.
// - Power down bit stops suspend and wake detection until written 0; enabled flags still reach the interrupt.
// - Forced reset raises the reset interrupt when enabled.
// - Wake in suspend sets wake flag, clears low power, raises wake line.
// - Several enabled flags give one interrupt request only.
module ucr_top
    import ucr_pkg::*;
#(
    parameter int IDLE_CYCLES = UCR_SUSPEND_IDLE_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire ucr_flags_s status_flags_i,
    input wire logic bus_traffic_i,
    input wire logic wake_event_i,
    output logic irq_low_o,
    output logic resume_drive_o,
    output logic suspend_mode_o,
    output logic low_power_o,
    output logic power_down_o,
    output logic periph_reset_o,
    output logic suspend_set_o,
    output logic wake_set_o,
    output logic bus_reset_set_o,
    output logic wakeup_line_o
);

    localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] IDLE_FULL = CNT_W'(IDLE_CYCLES);

    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [CNT_W-1:0] idle_cnt;
    logic wr_hit;
    logic rd_hit;
    logic wake_hit;
    logic watch_idle;
    logic reset_q;

    // Only the control offset is mapped here
    function automatic logic ctrl_sel(input logic [7:0] addr);
        return addr == UCR_CTRL_OFFSET;
    endfunction : ctrl_sel

    assign wr_hit = reg_wr_i && ctrl_sel(reg_addr_i);
    assign rd_hit = reg_rd_i && ctrl_sel(reg_addr_i);
    // Wake only counts while suspended and powered
    assign wake_hit = wake_event_i && ctrl[UCR_FORCE_SUSPEND_BIT] && !ctrl[UCR_POWER_DOWN_BIT];
    // Idle watch stops in suspend so no repeated suspend flags
    assign watch_idle = !ctrl[UCR_FORCE_SUSPEND_BIT] && !ctrl[UCR_POWER_DOWN_BIT]
                        && !ctrl[UCR_FORCE_RESET_BIT];

    // ****************************************
    // Control register
    // ****************************************
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_hit)
        begin
            next_ctrl = reg_wdata_i & UCR_CTRL_WR_MASK;
        end
        // Hardware clear beats a same-cycle software set, wake must not be lost
        if (wake_hit)
        begin
            next_ctrl[UCR_LOW_POWER_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            ctrl <= UCR_CTRL_RESET;
        else
            ctrl <= next_ctrl;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= 16'h0000;
        else if (rd_hit)
            reg_rdata_o <= {ctrl[UCR_IEN_MSB:UCR_IEN_LSB], UCR_RSVD_ZERO,
                            ctrl[UCR_RESUME_BIT:UCR_FORCE_RESET_BIT]};
        else
            reg_rdata_o <= 16'h0000;
    end

    assign resume_drive_o = ctrl[UCR_RESUME_BIT];
    assign suspend_mode_o = ctrl[UCR_FORCE_SUSPEND_BIT];
    assign low_power_o = ctrl[UCR_LOW_POWER_BIT];
    assign power_down_o = ctrl[UCR_POWER_DOWN_BIT];
    assign periph_reset_o = ctrl[UCR_FORCE_RESET_BIT];

    // ****************************************
    // Suspend detection
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            idle_cnt <= '0;
        else if (!watch_idle || bus_traffic_i)
            idle_cnt <= '0;
        else if (idle_cnt != IDLE_FULL)
            idle_cnt <= idle_cnt + CNT_W'(1);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            suspend_set_o <= 1'b0;
        else
            suspend_set_o <= watch_idle && !bus_traffic_i && (idle_cnt == IDLE_LAST);
    end

    // ****************************************
    // Wake and forced reset events
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            wake_set_o <= 1'b0;
        else
            wake_set_o <= wake_hit;
    end

    // Line stays up until software leaves suspend
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            wakeup_line_o <= 1'b0;
        else if (wake_hit)
            wakeup_line_o <= 1'b1;
        else if (!ctrl[UCR_FORCE_SUSPEND_BIT])
            wakeup_line_o <= 1'b0;
    end

    // Reset value has force reset set, so no pulse right after reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            reset_q <= 1'b1;
            bus_reset_set_o <= 1'b0;
        end
        else
        begin
            reset_q <= ctrl[UCR_FORCE_RESET_BIT];
            bus_reset_set_o <= ctrl[UCR_FORCE_RESET_BIT] && !reset_q;
        end
    end

    ucr_irq_gate u_irq_gate (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .flags_i(status_flags_i),
        .enable_i(ctrl[UCR_IEN_MSB:UCR_IEN_LSB]),
        .force_reset_i(ctrl[UCR_FORCE_RESET_BIT]),
        .irq_o(irq_low_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    resume_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_hit && reg_wdata_i[UCR_RESUME_BIT]) |=> resume_drive_o)
        else $error("resume not driven after write");

    suspend_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_hit && reg_wdata_i[UCR_FORCE_SUSPEND_BIT]) |=> suspend_mode_o ##1 !suspend_set_o)
        else $error("force suspend write not applied");

    idle_suspend_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(suspend_set_o) |-> idle_cnt == IDLE_FULL && !$past(bus_traffic_i))
        else $error("suspend flagged before idle time");

    wake_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wake_hit |=> !low_power_o && wake_set_o && wakeup_line_o)
        else $error("wake did not clear low power or raise line");

    power_down_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        power_down_o ##1 power_down_o |-> !suspend_set_o && !wake_set_o)
        else $error("activity while powered down");

    force_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(periph_reset_o) |=> bus_reset_set_o ##1 !bus_reset_set_o)
        else $error("forced reset pulse wrong");

    reserved_read_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rd_hit |=> reg_rdata_o[UCR_IEN_LSB-1:UCR_RESUME_BIT+1] == UCR_RSVD_ZERO
            && reg_rdata_o[UCR_RESUME_BIT:UCR_FORCE_RESET_BIT]
            == $past(ctrl[UCR_RESUME_BIT:UCR_FORCE_RESET_BIT]))
        else $error("reserved bits not zero on read");

endmodule : ucr_top

`default_nettype wire

// ==== core/ucr_pkg.sv ====
// Purpose: Shared constants and types for the USB control register block
// Assumes: 20 MHz register clock, 16-bit register data
// Notes: Event flag order matches the interrupt enable bits 15..8
`default_nettype none

package ucr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] UCR_CTRL_OFFSET = 8'h40;
    localparam logic [15:0] UCR_CTRL_RESET = 16'h0003;
    // Bits 7..5 are unassigned and never stored
    localparam logic [15:0] UCR_CTRL_WR_MASK = 16'hff1f;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int UCR_IEN_LSB = 8;
    localparam int UCR_IEN_MSB = 15;
    localparam int UCR_BUS_RESET_IEN_BIT = 10;
    localparam int UCR_RESUME_BIT = 4;
    localparam int UCR_FORCE_SUSPEND_BIT = 3;
    localparam int UCR_LOW_POWER_BIT = 2;
    localparam int UCR_POWER_DOWN_BIT = 1;
    localparam int UCR_FORCE_RESET_BIT = 0;
    localparam logic [2:0] UCR_RSVD_ZERO = 3'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int UCR_CLK_PERIOD_NS = 50;
    localparam int UCR_SUSPEND_IDLE_US = 3000;
    localparam int UCR_SUSPEND_IDLE_CYCLES = (UCR_SUSPEND_IDLE_US * 1000) / UCR_CLK_PERIOD_NS;

    // ****************************************
    // Event flags from the status register
    // ****************************************
    typedef struct packed {
        logic good_transfer_flag;
        logic packet_mem_overrun;
        logic bus_error_flag;
        logic wake_flag;
        logic suspend_flag;
        logic bus_reset_flag;
        logic frame_start_flag;
        logic expected_frame_event;
    } ucr_flags_s;

endpackage : ucr_pkg

`default_nettype wire

// ==== core/ucr_irq_gate.sv ====
// Purpose: Combine masked event flags into the single low-priority interrupt
// Assumes: Flags and enables are synchronous to ref_clk_i
// Notes: Output is registered, one cycle after its cause
`timescale 1ns/100ps
`default_nettype none

module ucr_irq_gate
    import ucr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire ucr_flags_s flags_i,
    input wire logic [7:0] enable_i,
    input wire logic force_reset_i,
    output logic irq_o
);

    // Enable slot of the bus reset source inside the enable byte
    localparam int RESET_IEN_IDX = UCR_BUS_RESET_IEN_BIT - UCR_IEN_LSB;

    logic next_irq;

    always_comb
    begin
        // One OR over all masked sources gives one request, not one per flag
        next_irq = |(flags_i & enable_i);
        // Forced reset requests like a bus reset when that source is enabled
        next_irq = next_irq | (force_reset_i & enable_i[RESET_IEN_IDX]);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            irq_o <= next_irq;
    end

    // ****************************************
    // Checks
    // ****************************************
    masked_source_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rstn_i ##1 irq_o |-> (|($past(flags_i) & $past(enable_i)))
            || ($past(force_reset_i) && $past(enable_i[RESET_IEN_IDX])))
        else $error("interrupt raised with no enabled source");

    all_masked_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (enable_i == 8'h00) [*2] |-> !irq_o)
        else $error("interrupt raised while all sources masked");

    flag_enabled_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (|(flags_i & enable_i)) |=> irq_o)
        else $error("enabled flag did not raise interrupt");

    forced_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (force_reset_i && enable_i[RESET_IEN_IDX]) |=> irq_o)
        else $error("forced reset did not raise interrupt");

endmodule : ucr_irq_gate

`default_nettype wire

// ==== verif/ucr_host_model.sv ====
// Purpose: Behavioural USB host on the far side of the control block
// Assumes: Host traffic is one level per clock cycle
// Notes: A silent host sends nothing, so the suspend timer can run
`timescale 1ns/100ps
`default_nettype none
module ucr_host_model
(
    input wire logic ref_clk_i,
    input wire logic silent_i,
    input wire logic resume_i,
    output logic traffic_o,
    output logic wake_o
);
    always_ff @(posedge ref_clk_i)
    begin
        // Frames keep the idle timer clear while the host is awake
        traffic_o <= !silent_i;
        wake_o <= resume_i;
    end
endmodule : ucr_host_model
`default_nettype wire

// ==== verif/tb_ucr_top.sv ====
// Purpose: Self-checking bench for the USB control register block
// Assumes: Idle count shortened to 20 cycles
// Notes: Host model supplies traffic and wake signalling
`timescale 1ns/100ps
`default_nettype none
module tb_ucr_top;
    import ucr_pkg::*;
    localparam int IDLE = 20;
    localparam logic [7:0] CTL = UCR_CTRL_OFFSET;
    logic clk, rstn, wr, rd, silent, resume, traffic, wake, irq, res_drv, susp, lowp;
    logic power_down, prst, susp_set, wake_set, rst_set, wline;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, d;
    ucr_flags_s flags;
    int bad_count, compares, cycles, n, i;

    ucr_top #(.IDLE_CYCLES(IDLE)) ucr_top_i (.ref_clk_i(clk), .rstn_i(rstn),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .status_flags_i(flags), .bus_traffic_i(traffic),
        .wake_event_i(wake), .irq_low_o(irq), .resume_drive_o(res_drv),
        .suspend_mode_o(susp), .low_power_o(lowp), .power_down_o(power_down),
        .periph_reset_o(prst), .suspend_set_o(susp_set), .wake_set_o(wake_set),
        .bus_reset_set_o(rst_set), .wakeup_line_o(wline));
    ucr_host_model ucr_host_model_i (.ref_clk_i(clk), .silent_i(silent),
        .resume_i(resume), .traffic_o(traffic), .wake_o(wake));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        // Full run needs about 20200 cycles
        if (cycles == 40000)
        begin
            bad_count++;
            results();
        end
    end

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rd_reg(CTL);
        check("ctrl reset", d, UCR_CTRL_RESET);
        check("held off", {14'h0, power_down, prst}, 16'h0003);
    endtask : t_reset

    task t_masks;
        for (i = 0; i < 8; i++)
        begin
            wr_reg(CTL, 16'h0100 << i);
            @(posedge clk);
            flags <= ucr_flags_s'(8'h01 << i);
            repeat (3) @(posedge clk);
            #1;
            check("irq on", 16'(irq), 16'h0001);
            wr_reg(CTL, ~(16'h0100 << i) & 16'hff00);
            repeat (2) @(posedge clk);
            #1;
            check("irq off", 16'(irq), 16'h0000);
        end
        wr_reg(CTL, 16'hff00);
        @(posedge clk);
        flags <= 8'hff;
        repeat (3) @(posedge clk);
        #1;
        check("irq all", 16'(irq), 16'h0001);
        @(posedge clk);
        flags <= 8'h00;
        repeat (3) @(posedge clk);
        #1;
        check("irq clear", 16'(irq), 16'h0000);
    endtask : t_masks

    task t_reserved;
        wr_reg(CTL, 16'hffe0);
        wr_reg(8'h44, 16'h00ff);
        rd_reg(CTL);
        check("spare bits", d, 16'hff00);
        rd_reg(8'h44);
        check("unmapped", d, 16'h0000);
    endtask : t_reserved

    task t_force;
        wr_reg(CTL, 16'h0400);
        wr_reg(CTL, 16'h0401);
        check("force rst", 16'(prst), 16'h0001);
        n = 0;
        while (rst_set !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("rst pulse", 16'(rst_set), 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        check("rst irq", 16'(irq), 16'h0001);
        wr_reg(CTL, 16'h0002);
        check("power_down", {14'h0, power_down, prst}, 16'h0002);
        wr_reg(CTL, 16'h0000);
        check("power_down off", 16'(power_down), 16'h0000);
    endtask : t_force

    task t_suspend;
        @(posedge clk);
        silent <= 1'b1;
        n = 0;
        while (susp_set !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("idle time", 16'(n >= IDLE && n <= IDLE + 2), 16'h0001);
        wr_reg(CTL, 16'h0008);
        check("suspend", 16'(susp), 16'h0001);
        wr_reg(CTL, 16'h000c);
        check("low power", 16'(lowp), 16'h0001);
        @(posedge clk);
        resume <= 1'b1;
        @(posedge clk);
        resume <= 1'b0;
        n = 0;
        while (wake_set !== 1'b1 && n < 5)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("wake pulse", 16'(wake_set), 16'h0001);
        check("lp cleared", 16'(lowp), 16'h0000);
        check("wake line", 16'(wline), 16'h0001);
        @(posedge clk);
        silent <= 1'b0;
        wr_reg(CTL, 16'h0018);
        check("resume on", 16'(res_drv), 16'h0001);
        // One ms of resume signalling at 20 MHz
        repeat (20000) @(posedge clk);
        #1;
        check("resume held", 16'(res_drv), 16'h0001);
        wr_reg(CTL, 16'h0000);
        @(posedge clk);
        #1;
        check("line drop", {14'h0, res_drv, wline}, 16'h0000);
    endtask : t_suspend

    task results;
        $display("Comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial
    begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        flags = 8'h00;
        silent = 1'b0;
        resume = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_masks();
        t_reserved();
        t_force();
        t_suspend();
        results();
    end
endmodule : tb_ucr_top
`default_nettype wire
